// ### hw/fan_tach_pkg.sv
/*
 * Constants, register map and carrier types of the fan speed monitor.
 * Assumes a 125 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package fan_tach_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS  = 8;
   localparam int unsigned TICK_PERIOD_NS = 10000;
   localparam int unsigned TICK_CYCLES    = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [10:0] TICK_LAST      = 11'(TICK_CYCLES - 1);
   localparam logic [1:0]  FILTER_TICKS   = 2'h2;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [31:0] OFS_CONTROL = 32'h0000_0000;
   localparam logic [31:0] OFS_FLAGS   = 32'h0000_0004;
   localparam logic [31:0] OFS_UPPER   = 32'h0000_0008;
   localparam logic [31:0] OFS_LOWER   = 32'h0000_000c;

   localparam int CTL_TOGGLE_IE = 15;
   localparam int CTL_READY_IE  = 14;
   localparam int CTL_EDGES_HI  = 12;
   localparam int CTL_EDGES_LO  = 11;
   localparam int CTL_MODE      = 10;
   localparam int CTL_FILTER    = 8;
   localparam int CTL_ENABLE    = 1;
   localparam int CTL_LIMIT_IE  = 0;
   localparam int CTL_READ_LO   = 16;

   localparam int STS_READY  = 3;
   localparam int STS_TOGGLE = 2;
   localparam int STS_PIN    = 1;
   localparam int STS_LIMIT  = 0;

   localparam logic [15:0] UPPER_RESET = 16'hffff;
   localparam logic [15:0] LOWER_RESET = 16'h0000;
   localparam logic [15:0] COUNT_MAX   = 16'hffff;
   localparam logic [15:0] COUNT_ZERO  = 16'h0000;

   localparam logic [1:0] EDGES_CODE_3 = 2'h1;
   localparam logic [1:0] EDGES_CODE_5 = 2'h2;
   localparam logic [1:0] EDGES_CODE_9 = 2'h3;
   localparam logic [3:0] EDGES_3      = 4'h3;
   localparam logic [3:0] EDGES_5      = 4'h5;
   localparam logic [3:0] EDGES_9      = 4'h9;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      SEL_CONTROL = 3'h0,
      SEL_FLAGS   = 3'h1,
      SEL_UPPER   = 3'h3,
      SEL_LOWER   = 3'h2,
      SEL_NONE    = 3'h6
   } reg_sel_t;

   typedef struct packed {
      logic [31:0] awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      logic [31:0] araddr;
      logic        arvalid;
      logic        rready;
   } axil_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } axil_rsp_t;

   typedef struct packed {
      logic       toggle_ie;
      logic       ready_ie;
      logic [1:0] edges;
      logic       mode;
      logic       filter;
      logic       enable;
      logic       limit_ie;
   } ctrl_t;

   typedef struct packed {
      logic ready;
      logic toggle;
      logic limit;
   } flags_t;

   typedef struct packed {
      axil_rsp_t   rsp;
      logic [31:0] awaddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      ctrl_t       ctrl;
      flags_t      flags;
      logic [15:0] upper;
      logic [15:0] lower;
      logic [15:0] reading;
      logic [15:0] counter;
      logic [3:0]  edge_cnt;
      logic [10:0] tick_cnt;
      logic [2:0]  sync;
      logic        pin;
      logic [1:0]  filt_cnt;
      logic        level;
      logic        irq;
   } mon_state_t;

endpackage

// ### hw/fan_tachometer_monitor.sv
/*
 * Fan speed monitor: tach input synchroniser, glitch filter, free-running
 * edge counter or 100 kHz interval counter, limit check, flags, interrupt,
 * and an AXI4-Lite register slave.
 * Assumes tach_in is asynchronous to aclk and the bus master keeps
 * AXI4-Lite handshakes; one clock, synchronous active-low reset.
 */
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ns

module fan_tachometer_monitor (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire fan_tach_pkg::axil_req_t axil_req,
   output fan_tach_pkg::axil_rsp_t     axil_rsp,
   input  wire logic                   tach_in,
   output logic                        tach_irq
);
   import fan_tach_pkg::*;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic reg_sel_t decode(input logic [31:0] addr);
      unique case (addr)
         OFS_CONTROL: decode = SEL_CONTROL;
         OFS_FLAGS:   decode = SEL_FLAGS;
         OFS_UPPER:   decode = SEL_UPPER;
         OFS_LOWER:   decode = SEL_LOWER;
         default:     decode = SEL_NONE;
      endcase
   endfunction

   // Code 00 is undefined; it is treated like the 3-edge setting
   function automatic logic [3:0] edge_target(input logic [1:0] code);
      unique case (code)
         EDGES_CODE_9: edge_target = EDGES_9;
         EDGES_CODE_5: edge_target = EDGES_5;
         EDGES_CODE_3: edge_target = EDGES_3;
         default:      edge_target = EDGES_3;
      endcase
   endfunction

   mon_state_t s_reg;
   mon_state_t s_next;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      logic       tick;
      logic       chg;
      logic       rise;
      logic       wr_go;
      logic       latch;
      logic [15:0] cnt_inc;
      logic [3:0]  edge_inc;
      reg_sel_t   wsel;
      reg_sel_t   rsel;
      logic [31:0] rword;

      s_next   = s_reg;
      tick     = 1'b0;
      chg      = 1'b0;
      rise     = 1'b0;
      latch    = 1'b0;
      cnt_inc  = s_reg.counter;
      edge_inc = s_reg.edge_cnt;
      wsel     = decode(s_reg.awaddr);
      rsel     = decode(axil_req.araddr);
      rword    = 32'h0000_0000;
      wr_go    = !s_reg.rsp.awready && !s_reg.rsp.wready && !s_reg.rsp.bvalid;

      // Three-stage synchroniser; only stages two and three are compared
      s_next.sync = {s_reg.sync[1:0], tach_in};
      if (s_reg.sync[1] == s_reg.sync[2]) begin
         s_next.pin = s_reg.sync[2];
      end

      // 100 kHz tick divider, held at zero while the monitor is idle
      if (s_reg.ctrl.enable) begin
         if (s_reg.tick_cnt == TICK_LAST) begin
            s_next.tick_cnt = '0;
            tick            = 1'b1;
         end else begin
            s_next.tick_cnt = s_reg.tick_cnt + 11'h001;
         end
      end else begin
         s_next.tick_cnt = '0;
      end

      // Glitch filter; a new level must hold for two ticks
      if (!s_reg.ctrl.enable || !s_reg.ctrl.filter) begin
         s_next.level    = s_reg.pin;
         s_next.filt_cnt = '0;
      end else if (s_reg.pin == s_reg.level) begin
         s_next.filt_cnt = '0;
      end else if (tick) begin
         if (s_reg.filt_cnt + 2'h1 == FILTER_TICKS) begin
            s_next.level    = s_reg.pin;
            s_next.filt_cnt = '0;
         end else begin
            s_next.filt_cnt = s_reg.filt_cnt + 2'h1;
         end
      end

      // Level following the pin while idle keeps enable from faking an edge
      chg  = s_reg.ctrl.enable && (s_next.level != s_reg.level);
      rise = chg && s_next.level;

      // Counting
      if (s_reg.ctrl.enable && s_reg.ctrl.mode) begin
         cnt_inc  = s_reg.counter + {15'h0000, tick};
         edge_inc = s_reg.edge_cnt + {3'h0, chg};
         if (chg && edge_inc >= edge_target(s_reg.ctrl.edges)) begin
            s_next.reading  = cnt_inc;
            s_next.counter  = COUNT_ZERO;
            s_next.edge_cnt = 4'h1;
            latch           = 1'b1;
         end else if (cnt_inc == COUNT_MAX) begin
            s_next.reading  = COUNT_MAX;
            s_next.counter  = COUNT_ZERO;
            s_next.edge_cnt = edge_inc;
            latch           = 1'b1;
         end else begin
            s_next.counter  = cnt_inc;
            s_next.edge_cnt = edge_inc;
         end
      end else if (s_reg.ctrl.enable) begin
         s_next.edge_cnt = '0;
         if (rise) begin
            s_next.counter = s_reg.counter + 16'h0001;
            s_next.reading = s_reg.counter + 16'h0001;
         end
      end

      // Register writes, one cycle after address and data are both held
      if (wr_go) begin
         s_next.rsp.bvalid = 1'b1;
         s_next.rsp.bresp  = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         unique case (wsel)
            SEL_CONTROL: begin
               if (s_reg.wstrb[0]) begin
                  s_next.ctrl.enable   = s_reg.wdata[CTL_ENABLE];
                  s_next.ctrl.limit_ie = s_reg.wdata[CTL_LIMIT_IE];
               end
               if (s_reg.wstrb[1]) begin
                  s_next.ctrl.toggle_ie = s_reg.wdata[CTL_TOGGLE_IE];
                  s_next.ctrl.ready_ie  = s_reg.wdata[CTL_READY_IE];
                  s_next.ctrl.edges     = s_reg.wdata[CTL_EDGES_HI:CTL_EDGES_LO];
                  s_next.ctrl.mode      = s_reg.wdata[CTL_MODE];
                  s_next.ctrl.filter    = s_reg.wdata[CTL_FILTER];
               end
            end
            SEL_FLAGS: begin
               if (s_reg.wstrb[0]) begin
                  if (s_reg.wdata[STS_READY]) begin
                     s_next.flags.ready = 1'b0;
                  end
                  if (s_reg.wdata[STS_TOGGLE]) begin
                     s_next.flags.toggle = 1'b0;
                  end
                  if (s_reg.wdata[STS_LIMIT]) begin
                     s_next.flags.limit = 1'b0;
                  end
               end
            end
            SEL_UPPER: begin
               if (s_reg.wstrb[0]) begin
                  s_next.upper[7:0] = s_reg.wdata[7:0];
               end
               if (s_reg.wstrb[1]) begin
                  s_next.upper[15:8] = s_reg.wdata[15:8];
               end
            end
            SEL_LOWER: begin
               if (s_reg.wstrb[0]) begin
                  s_next.lower[7:0] = s_reg.wdata[7:0];
               end
               if (s_reg.wstrb[1]) begin
                  s_next.lower[15:8] = s_reg.wdata[15:8];
               end
            end
            default: begin
            end
         endcase
      end

      // Flag setting comes after the clears so a coinciding event wins
      if (latch) begin
         s_next.flags.ready = 1'b1;
      end
      if (!s_reg.ctrl.mode) begin
         s_next.flags.ready = 1'b0;
      end
      if (chg) begin
         s_next.flags.toggle = 1'b1;
      end
      if (s_reg.ctrl.enable && (s_reg.reading > s_reg.upper
                                || s_reg.reading < s_reg.lower)) begin
         s_next.flags.limit = 1'b1;
      end

      s_next.irq = (s_next.flags.toggle && s_next.ctrl.toggle_ie)
                || (s_next.flags.ready && s_next.ctrl.ready_ie)
                || (s_next.flags.limit && s_next.ctrl.limit_ie);

      // Write address and data channels, taken in either order
      if (axil_req.awvalid && s_reg.rsp.awready) begin
         s_next.awaddr      = axil_req.awaddr;
         s_next.rsp.awready = 1'b0;
      end
      if (axil_req.wvalid && s_reg.rsp.wready) begin
         s_next.wdata      = axil_req.wdata;
         s_next.wstrb      = axil_req.wstrb;
         s_next.rsp.wready = 1'b0;
      end
      if (s_reg.rsp.bvalid && axil_req.bready) begin
         s_next.rsp.bvalid  = 1'b0;
         s_next.rsp.awready = 1'b1;
         s_next.rsp.wready  = 1'b1;
      end

      // Read channel; reads never disturb the counter
      unique case (rsel)
         SEL_CONTROL: begin
            rword[CTL_READ_LO +: 16]          = s_reg.reading;
            rword[CTL_TOGGLE_IE]              = s_reg.ctrl.toggle_ie;
            rword[CTL_READY_IE]               = s_reg.ctrl.ready_ie;
            rword[CTL_EDGES_HI:CTL_EDGES_LO]  = s_reg.ctrl.edges;
            rword[CTL_MODE]                   = s_reg.ctrl.mode;
            rword[CTL_FILTER]                 = s_reg.ctrl.filter;
            rword[CTL_ENABLE]                 = s_reg.ctrl.enable;
            rword[CTL_LIMIT_IE]               = s_reg.ctrl.limit_ie;
         end
         SEL_FLAGS: begin
            rword[STS_READY]  = s_reg.flags.ready;
            rword[STS_TOGGLE] = s_reg.flags.toggle;
            rword[STS_PIN]    = s_reg.pin;
            rword[STS_LIMIT]  = s_reg.flags.limit;
         end
         SEL_UPPER: begin
            rword[15:0] = s_reg.upper;
         end
         SEL_LOWER: begin
            rword[15:0] = s_reg.lower;
         end
         default: begin
         end
      endcase
      if (axil_req.arvalid && s_reg.rsp.arready) begin
         s_next.rsp.rdata   = rword;
         s_next.rsp.rresp   = (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         s_next.rsp.rvalid  = 1'b1;
         s_next.rsp.arready = 1'b0;
      end
      if (s_reg.rsp.rvalid && axil_req.rready) begin
         s_next.rsp.rvalid  = 1'b0;
         s_next.rsp.arready = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_reg             <= '0;
         s_reg.rsp.awready <= 1'b1;
         s_reg.rsp.wready  <= 1'b1;
         s_reg.rsp.arready <= 1'b1;
         s_reg.upper       <= UPPER_RESET;
         s_reg.lower       <= LOWER_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   assign axil_rsp = s_reg.rsp;
   assign tach_irq = s_reg.irq;

endmodule // fan_tachometer_monitor

// ### dv/fan_tach_chk.sv
/*
 * Checker of the fan speed monitor: bus answer timing, unmapped access,
 * pin status and quiet outputs after reset. Sees only the top ports.
 */
`timescale 1ns/1ns

module fan_tach_chk (
   input wire logic                    aclk,
   input wire logic                    aresetn,
   input wire fan_tach_pkg::axil_req_t axil_req,
   input wire fan_tach_pkg::axil_rsp_t axil_rsp,
   input wire logic                    tach_in,
   input wire logic                    tach_irq
);
   import fan_tach_pkg::*;
   logic       wr_take;
   logic       rd_take;
   logic       tach_q;
   logic [3:0] stab;
   logic       unmapped_r;
   logic       unmapped_w;
   assign wr_take = axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready;
   assign rd_take = axil_req.arvalid && axil_rsp.arready;
   assign unmapped_r = !(axil_req.araddr inside {OFS_CONTROL, OFS_FLAGS, OFS_UPPER, OFS_LOWER});
   assign unmapped_w = !(axil_req.awaddr inside {OFS_CONTROL, OFS_FLAGS, OFS_UPPER, OFS_LOWER});
   // Pin must stay put long enough to pass the synchroniser
   always_ff @(posedge aclk) begin
      tach_q <= tach_in;
      if (!aresetn || tach_in != tach_q) stab <= 4'h0;
      else if (stab != 4'hf) stab <= stab + 4'h1;
   end
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   a_write_answer: assert property (wr_take |-> ##2 axil_rsp.bvalid)
      else $error("write answer late");
   a_read_answer: assert property (rd_take |=> axil_rsp.rvalid && !axil_rsp.arready)
      else $error("read answer late");
   a_bresp_hold: assert property (axil_rsp.bvalid && !axil_req.bready
      |=> axil_rsp.bvalid && $stable(axil_rsp.bresp)) else $error("write answer dropped");
   a_rdata_hold: assert property (axil_rsp.rvalid && !axil_req.rready
      |=> axil_rsp.rvalid && $stable(axil_rsp.rdata)) else $error("read answer dropped");
   a_read_unmapped: assert property (rd_take && unmapped_r
      |=> axil_rsp.rresp == RESP_SLVERR && axil_rsp.rdata == 32'h0) else $error("bad read answer");
   a_write_unmapped: assert property (wr_take && unmapped_w
      |-> ##2 axil_rsp.bresp == RESP_SLVERR) else $error("bad write answer");
   a_bound_upper: assert property (
      rd_take && (axil_req.araddr == OFS_UPPER || axil_req.araddr == OFS_LOWER)
      |=> axil_rsp.rdata[31:16] == 16'h0) else $error("bound upper half not zero");
   a_pin_level: assert property (
      stab > 4'h8 && rd_take && axil_req.araddr == OFS_FLAGS
      |=> axil_rsp.rdata[STS_PIN] == $past(tach_in)) else $error("pin status wrong");
   a_reset_quiet: assert property (
      $rose(aresetn) |-> !tach_irq && !axil_rsp.bvalid && !axil_rsp.rvalid)
      else $error("outputs busy after reset");
   c_write: cover property (wr_take);
   c_read_flags: cover property (rd_take && axil_req.araddr == OFS_FLAGS);
   c_irq: cover property ($rose(tach_irq));
endmodule // fan_tach_chk

bind fan_tachometer_monitor fan_tach_chk u_fan_tach_chk (.aclk(aclk), .aresetn(aresetn),
   .axil_req(axil_req), .axil_rsp(axil_rsp), .tach_in(tach_in), .tach_irq(tach_irq));

// ### dv/fan_model.sv
/*
 * Fan model: square wave on the tach line while spinning, and an
 * inverted pulse of a set width on request. Runs on the bench clock.
 */
`timescale 1ns/1ns

module fan_model (
   input  wire logic        aclk,
   input  wire logic        spin,
   input  wire logic [15:0] half,
   input  wire logic        pulse,
   input  wire logic [15:0] pulse_len,
   output logic             tach_in
);
   logic [15:0] cnt = 16'h0;
   logic [15:0] left = 16'h0;
   logic        level = 1'b0;
   // A stopped fan holds its last level, as a stalled rotor does
   always @(posedge aclk) begin
      cnt <= (spin && cnt != half) ? cnt + 16'h1 : 16'h0;
      if (spin && cnt == half) level <= ~level;
      if (pulse) left <= pulse_len;
      else if (left != 16'h0) left <= left - 16'h1;
   end
   assign tach_in = level ^ (left != 16'h0);
endmodule // fan_model

// ### dv/fan_tachometer_monitor_tb_top.sv
/*
 * Bench of the fan speed monitor: register rows, then idle, edge,
 * filter, interval and limit cases. Assumes fan model and checker.
 */
`timescale 1ns/1ns

module fan_tachometer_monitor_tb_top;
   import fan_tach_pkg::*;
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic        do_wr;
      logic [31:0] exp;
      logic [1:0]  resp;
   } row_t;
   logic        aclk;
   logic        aresetn;
   axil_req_t   req;
   axil_rsp_t   rsp;
   logic        tach_in;
   logic        tach_irq;
   logic        spin;
   logic [15:0] half;
   logic        pulse;
   logic [15:0] pulse_len;
   logic [1:0]  resp;
   logic [31:0] rv;
   logic [15:0] cnt_exp;
   logic [15:0] ticks;
   int          n_fail;
   int          comparisons;
   int          rises;
   row_t        rows [8] = '{
      '{OFS_CONTROL, 32'h0, 1'b0, 32'h0, RESP_OKAY},
      '{OFS_UPPER, 32'h0, 1'b0, 32'hffff, RESP_OKAY},
      '{OFS_LOWER, 32'h0, 1'b0, 32'h0, RESP_OKAY},
      '{32'h10, 32'hffffffff, 1'b1, 32'h0, RESP_SLVERR},
      '{OFS_UPPER, 32'hdead1234, 1'b1, 32'h1234, RESP_OKAY},
      '{OFS_CONTROL, 32'hffff0000, 1'b1, 32'h0, RESP_OKAY},
      '{OFS_FLAGS, 32'hf, 1'b1, 32'h0, RESP_OKAY},
      '{OFS_UPPER, 32'hffff, 1'b1, 32'hffff, RESP_OKAY}};

   fan_tachometer_monitor u_fan_tachometer_monitor (.aclk(aclk), .aresetn(aresetn),
      .axil_req(req), .axil_rsp(rsp), .tach_in(tach_in), .tach_irq(tach_irq));
   fan_model u_fan_model (.aclk(aclk), .spin(spin), .half(half), .pulse(pulse),
      .pulse_len(pulse_len), .tach_in(tach_in));

   always @(posedge tach_in) rises++;

   // ------------------------------------------------------------
   // Bus tasks; handshakes are judged on the values seen at the rising edge
   // ------------------------------------------------------------
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic ta;
      logic tw;
      logic done;
      @(posedge aclk);
      done = 1'b0;
      req.awaddr <= a;
      req.wdata <= d;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         ta = req.awvalid && rsp.awready;
         tw = req.wvalid && rsp.wready;
         done = req.bready && rsp.bvalid;
         if (done) resp = rsp.bresp;
         if (ta) req.awvalid <= 1'b0;
         if (tw) req.wvalid <= 1'b0;
         if (done) req.bready <= 1'b0;
      end
   endtask

   task automatic rd(input logic [31:0] a);
      logic ta;
      logic done;
      @(posedge aclk);
      done = 1'b0;
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         ta = req.arvalid && rsp.arready;
         done = req.rready && rsp.rvalid;
         if (done) rv = rsp.rdata;
         if (done) resp = rsp.rresp;
         if (ta) req.arvalid <= 1'b0;
         if (done) req.rready <= 1'b0;
      end
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic run(input int n);
      spin <= 1'b1;
      repeat (n) @(posedge aclk);
      spin <= 1'b0;
      repeat (10) @(posedge aclk);
   endtask

   task automatic fire(input logic [15:0] n);
      pulse_len <= n;
      pulse <= 1'b1;
      @(posedge aclk);
      pulse <= 1'b0;
      repeat (int'(n) + 4000) @(posedge aclk);
   endtask

   task automatic give_verdict;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   // Longest wait is two 9-edge intervals; the span leaves ample room
   initial begin
      repeat (90000) @(posedge aclk);
      n_fail++;
      give_verdict();
   end

   initial begin
      req = '0;
      req.wstrb = 4'hf;
      aresetn = 1'b0;
      {spin, pulse} = 2'b00;
      half = 16'h14;
      pulse_len = 16'h0;
      {n_fail, comparisons, rises} = {32'h0, 32'h0, 32'h0};
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(OFS_FLAGS);
      chk(rv, 32'h0);
      foreach (rows[i]) begin
         if (rows[i].do_wr) wr(rows[i].addr, rows[i].wdata);
         if (rows[i].do_wr) chk(32'(resp), 32'(rows[i].resp));
         rd(rows[i].addr);
         chk(rv, rows[i].exp);
         chk(32'(resp), 32'(rows[i].resp));
      end
      run(200);
      rd(OFS_CONTROL);
      chk(rv, 32'h0);
      rd(OFS_FLAGS);
      chk(rv, {30'h0, tach_in, 1'b0});
      wr(OFS_CONTROL, 32'h8002);
      rises = 0;
      run(300);
      cnt_exp = rises[15:0];
      rd(OFS_CONTROL);
      chk(rv, {cnt_exp, 16'h8002});
      chk(32'(tach_irq), 32'h1);
      rd(OFS_FLAGS);
      chk(rv, {28'h0, 2'b01, tach_in, 1'b0});
      wr(OFS_CONTROL, 32'h0002);
      @(negedge aclk);
      chk(32'(tach_irq), 32'h0);
      wr(OFS_FLAGS, 32'h4);
      wr(OFS_CONTROL, 32'h0102);
      fire(16'd200);
      rd(OFS_FLAGS);
      chk(rv, {30'h0, tach_in, 1'b0});
      fire(16'd5000);
      rd(OFS_CONTROL);
      chk(rv, {cnt_exp + 16'h1, 16'h0102});
      half <= 16'd1249;
      spin <= 1'b1;
      for (int c = 1; c < 4; c++) begin
         wr(OFS_CONTROL, 32'h4402 | (32'(c) << CTL_EDGES_LO));
         wr(OFS_FLAGS, 32'h8);
         @(negedge aclk iff tach_irq);
         wr(OFS_FLAGS, 32'h8);
         @(negedge aclk iff tach_irq);
         rd(OFS_CONTROL);
         ticks = (c == 1) ? 16'h2 : (c == 2) ? 16'h4 : 16'h8;
         chk(32'(rv[31:16] + 16'h1 >= ticks && rv[31:16] <= ticks + 16'h1), 32'h1);
         rd(OFS_FLAGS);
         chk(32'(rv[STS_READY]), 32'h1);
      end
      wr(OFS_CONTROL, 32'h1c03);
      wr(OFS_UPPER, 32'h1);
      repeat (3) @(negedge aclk);
      chk(32'(tach_irq), 32'h1);
      wr(OFS_UPPER, 32'hffff);
      wr(OFS_LOWER, 32'hff00);
      wr(OFS_FLAGS, 32'h1);
      rd(OFS_FLAGS);
      chk(32'(rv[STS_LIMIT]), 32'h1);
      wr(OFS_LOWER, 32'h0);
      wr(OFS_FLAGS, 32'h1);
      rd(OFS_FLAGS);
      chk(32'(rv[STS_LIMIT]), 32'h0);
      chk(32'(tach_irq), 32'h0);
      give_verdict();
   end
endmodule // fan_tachometer_monitor_tb_top
